/* pwm_art_pkg.sv */
// Package for the auto-reload PWM timer: register offsets, field positions,
// reset values and bus carriers.
// Assumes a 32-bit APB master; offsets are word indices (byte address = 4 * index).
package pwm_art_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_DUTY_CH3 = 8'h73;
	localparam logic [7:0] IDX_DUTY_CH2 = 8'h74;
	localparam logic [7:0] IDX_DUTY_CH1 = 8'h75;
	localparam logic [7:0] IDX_DUTY_CH0 = 8'h76;
	localparam logic [7:0] IDX_OUTPUT_CONTROL = 8'h77;
	localparam logic [7:0] IDX_TIMER_CSR = 8'h78;
	localparam logic [7:0] IDX_COUNTER_WINDOW = 8'h79;
	localparam logic [7:0] IDX_RELOAD_VALUE = 8'h7A;
	localparam logic [7:0] IDX_CAPTURE_CSR = 8'h7B;
	localparam logic [7:0] IDX_CAPTURE_VALUE_1 = 8'h7C;
	localparam logic [7:0] IDX_CAPTURE_VALUE_2 = 8'h7D;
	localparam int ADDR_LSB = 2;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TCS_EXT_CLOCK_SELECT = 7;
	localparam int TCS_PRESCALE_HI = 6;
	localparam int TCS_PRESCALE_LO = 4;
	localparam int TCS_COUNTER_RUN = 3;
	localparam int TCS_FORCE_RELOAD = 2;
	localparam int TCS_OVERFLOW_IRQ_EN = 1;
	localparam int TCS_OVERFLOW_FLAG = 0;
	localparam int OC_ENABLE_LO = 4;
	localparam int OC_POLARITY_LO = 0;
	localparam int CCS_EDGE_LO = 4;
	localparam int CCS_IRQ_EN_LO = 2;
	localparam int CCS_FLAG_LO = 0;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] COUNT_TOP = 8'hFF;
	localparam logic [6:0] PRESCALE_RESET = 7'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// APB request carrier
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

	// APB answer carrier
	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} apb_rsp_t;

endpackage : pwm_art_pkg

/* pwm_art_timer.sv */
// Auto-reload 8-bit PWM timer with four waveform outputs and two captures.
// Assumes one 10 MHz pclk, an APB master, and synchronous pin inputs.
// Capture and external clock pins arrive already in the pclk domain.
// Register index is paddr[9:2]; the other address bits are ignored.
//
// Functional notes
// - Counter window reads and writes live counter
// - Overflow loads reload value into counter
// - Overflow drives enabled outputs to overflow level
// - Duty resolution follows the reload value
// - Control bits 7:4 enable each output
// - Output high while counter <= shadow
// - Polarity change inverts output immediately
// - Duty register sets second edge via shadow
// - Capture status bits 7:6 read zero
// - Edge bit: 0 falling, 1 rising
// - Capture irq enables gate each request
// - Capture flag set on capture, cleared by read
// - Capture copies counter; value register read-only
// - Register map from 73h to 7Dh
// - All registers read zero after reset
// - Shadows hidden, reloaded at every overflow
// - Overflow sets flag; status read clears it
// - Force reload loads counter, clears prescaler
// - Prescale select divides by 1 to 128
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module pwm_art_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clock_in,
	input wire logic [1:0] capture_pin,
	output logic [3:0] waveform_out,
	output logic [3:0] waveform_oe,
	output logic overflow_irq,
	output logic [1:0] capture_irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	pwm_art_pkg::apb_req_t req;
	pwm_art_pkg::apb_rsp_t rsp_q, rsp_d;
	logic [7:0] idx;
	logic wr_acc, rd_acc, setup;

	// Bundle the bus request and find the register index
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign idx = req.addr[pwm_art_pkg::ADDR_LSB +: 8];
	assign setup = req.sel & ~req.enable;
	// Back-to-back transfers are fine: a setup may follow an access at once
	// Access phase; slave answers with pready in the second cycle
	assign wr_acc = req.sel & req.enable & req.write & rsp_q.ready;
	assign rd_acc = req.sel & req.enable & ~req.write & rsp_q.ready;

	// Decode of the mapped index range, used by the read answer
	// register map
	function automatic logic mapped(input logic [7:0] i);
		mapped = (i >= pwm_art_pkg::IDX_DUTY_CH3) && (i <= pwm_art_pkg::IDX_CAPTURE_VALUE_2);
	endfunction : mapped

	// Detect a selected transition on a capture input
	function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
		edge_hit = rising ? (~prev & cur) : (prev & ~cur);
	endfunction : edge_hit

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	// Duty registers and their compare shadows
	logic [7:0] duty_q [4], duty_d [4];
	logic [7:0] shadow_q [4], shadow_d [4];
	// Output enables and polarities
	logic [7:0] output_control_q, output_control_d;
	// Timer control and status fields
	logic ext_sel_q, ext_sel_d;
	logic [2:0] prescale_sel_q, prescale_sel_d;
	logic run_q, run_d;
	logic ovf_ie_q, ovf_ie_d;
	logic ovf_flag_q, ovf_flag_d;
	// Counter, prescaler and reload value
	logic [7:0] counter_q, counter_d;
	logic [6:0] prescaler_q, prescaler_d;
	logic [7:0] reload_q, reload_d;
	// Capture control, flags and values
	logic [1:0] cap_edge_q, cap_edge_d;
	logic [1:0] cap_ie_q, cap_ie_d;
	logic [1:0] cap_flag_q, cap_flag_d;
	logic [7:0] cap_val_q [2], cap_val_d [2];
	// Pin history for edge detection
	logic [1:0] cap_prev_q, cap_prev_d;
	logic ext_prev_q, ext_prev_d;
	// Waveform levels, pins and interrupt flops
	logic [3:0] level_q, level_d;
	logic [3:0] wave_q, wave_d;
	logic [3:0] oe_q, oe_d;
	logic ovf_irq_q, ovf_irq_d;
	logic [1:0] cap_irq_q, cap_irq_d;

	logic input_tick, count_tick, overflow;
	logic [7:0] tcs_read, ccs_read;
	logic [1:0] capture_ev;

	// ------------------------------------------------------------
	// Prescaler and counter tick
	// ------------------------------------------------------------
	// An external edge is found against the last sampled pin level
	// input clock is pclk or an external edge count
	assign input_tick = ext_sel_q ? (ext_clock_in & ~ext_prev_q) : 1'b1;

	// A clear run bit blocks every tick, which freezes the counter
	// divide by power of two
	always_comb begin
		logic [6:0] mask;
		// Mask covers the prescaler bits that must all be ones
		mask = 7'((8'h01 << prescale_sel_q) - 8'h01);
		count_tick = run_q & input_tick & ((prescaler_q & mask) == mask);
	end

	// overflow is a tick at FFh
	assign overflow = count_tick & (counter_q == pwm_art_pkg::COUNT_TOP);

	// Capture edges; a pending flag blocks a new transfer
	// Edge is found between the last sample and the pin now
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			capture_ev[c] = edge_hit(cap_prev_q[c], capture_pin[c], cap_edge_q[c]);
		end
	end

	// Readback of the status registers
	// force reload bit reads zero
	assign tcs_read = {ext_sel_q, prescale_sel_q, run_q, 1'b0, ovf_ie_q, ovf_flag_q};
	assign ccs_read = {2'b00, cap_edge_q, cap_ie_q, cap_flag_q};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		// Every register except the pin history holds unless something below changes it; the pin history follows the pins
		duty_d = duty_q;
		shadow_d = shadow_q;
		output_control_d = output_control_q;
		ext_sel_d = ext_sel_q;
		prescale_sel_d = prescale_sel_q;
		run_d = run_q;
		ovf_ie_d = ovf_ie_q;
		ovf_flag_d = ovf_flag_q;
		counter_d = counter_q;
		prescaler_d = prescaler_q;
		reload_d = reload_q;
		cap_edge_d = cap_edge_q;
		cap_ie_d = cap_ie_q;
		cap_flag_d = cap_flag_q;
		cap_val_d = cap_val_q;
		cap_prev_d = capture_pin;
		ext_prev_d = ext_clock_in;
		level_d = level_q;
		rsp_d = rsp_q;

		// run bit freezes prescaler and counter
		if (run_q && input_tick) begin
			prescaler_d = 7'(prescaler_q + 7'h01);
		end
		if (count_tick) begin
			counter_d = 8'(counter_q + 8'h01);
		end
		if (overflow) begin
			counter_d = reload_q;
			// resolution is 256 minus reload
			// Fewer counts per period give coarser duty steps
			// shadows refresh at overflow
			for (int c = 0; c < 4; c++) begin
				shadow_d[c] = duty_q[c];
			end
			level_d = 4'hF;
		end

		// Bus writes land only at the access edge, with pready high
		if (wr_acc) begin
			unique case (idx)
				pwm_art_pkg::IDX_DUTY_CH3: duty_d[3] = req.wdata[7:0];
				pwm_art_pkg::IDX_DUTY_CH2: duty_d[2] = req.wdata[7:0];
				pwm_art_pkg::IDX_DUTY_CH1: duty_d[1] = req.wdata[7:0];
				pwm_art_pkg::IDX_DUTY_CH0: duty_d[0] = req.wdata[7:0];
				pwm_art_pkg::IDX_OUTPUT_CONTROL: output_control_d = req.wdata[7:0];
				pwm_art_pkg::IDX_TIMER_CSR: begin
					ext_sel_d = req.wdata[pwm_art_pkg::TCS_EXT_CLOCK_SELECT];
					prescale_sel_d = req.wdata[pwm_art_pkg::TCS_PRESCALE_HI:pwm_art_pkg::TCS_PRESCALE_LO];
					run_d = req.wdata[pwm_art_pkg::TCS_COUNTER_RUN];
					ovf_ie_d = req.wdata[pwm_art_pkg::TCS_OVERFLOW_IRQ_EN];
					if (req.wdata[pwm_art_pkg::TCS_FORCE_RELOAD]) begin
						counter_d = reload_q;
						prescaler_d = pwm_art_pkg::PRESCALE_RESET;
					end
				end
				pwm_art_pkg::IDX_COUNTER_WINDOW: begin
					counter_d = req.wdata[7:0];
					prescaler_d = pwm_art_pkg::PRESCALE_RESET;
				end
				pwm_art_pkg::IDX_RELOAD_VALUE: reload_d = req.wdata[7:0];
				pwm_art_pkg::IDX_CAPTURE_CSR: begin
					cap_edge_d = req.wdata[pwm_art_pkg::CCS_EDGE_LO +: 2];
					cap_ie_d = req.wdata[pwm_art_pkg::CCS_IRQ_EN_LO +: 2];
				end
				default: ;
			endcase
		end

		// level falls once the next count passes its shadow
		// Next values are compared so the pin stays in step with the counter
		for (int c = 0; c < 4; c++) begin
			if (!overflow && counter_d > shadow_d[c]) begin
				level_d[c] = 1'b0;
			end
		end

		// Read side effects
		// Clears act only at the access edge, as writes do
		if (rd_acc) begin
			if (idx == pwm_art_pkg::IDX_TIMER_CSR) begin
				ovf_flag_d = 1'b0;
			end
			if (idx == pwm_art_pkg::IDX_CAPTURE_VALUE_1) begin
				cap_flag_d[0] = 1'b0;
			end
			if (idx == pwm_art_pkg::IDX_CAPTURE_VALUE_2) begin
				cap_flag_d[1] = 1'b0;
			end
		end
		// set wins over the read clear
		if (overflow) begin
			ovf_flag_d = 1'b1;
		end
		for (int c = 0; c < 2; c++) begin
			// latch counter; held while flag pending
			if (capture_ev[c] && !cap_flag_q[c]) begin
				cap_val_d[c] = counter_q;
				cap_flag_d[c] = 1'b1;
			end
		end

		// Bus answer: one wait state, data from the registers
		// Read data is taken at setup so it stands through the access cycle
		// Unmapped indices answer zero and never raise an error
		rsp_d.ready = setup;
		rsp_d.slverr = 1'b0;
		rsp_d.rdata = pwm_art_pkg::READ_UNMAPPED;
		if (setup && !req.write && mapped(idx)) begin
			unique case (idx)
				pwm_art_pkg::IDX_DUTY_CH3: rsp_d.rdata[7:0] = duty_q[3];
				pwm_art_pkg::IDX_DUTY_CH2: rsp_d.rdata[7:0] = duty_q[2];
				pwm_art_pkg::IDX_DUTY_CH1: rsp_d.rdata[7:0] = duty_q[1];
				pwm_art_pkg::IDX_DUTY_CH0: rsp_d.rdata[7:0] = duty_q[0];
				pwm_art_pkg::IDX_OUTPUT_CONTROL: rsp_d.rdata[7:0] = output_control_q;
				pwm_art_pkg::IDX_TIMER_CSR: rsp_d.rdata[7:0] = tcs_read;
				pwm_art_pkg::IDX_COUNTER_WINDOW: rsp_d.rdata[7:0] = counter_q;
				pwm_art_pkg::IDX_RELOAD_VALUE: rsp_d.rdata[7:0] = reload_q;
				pwm_art_pkg::IDX_CAPTURE_CSR: rsp_d.rdata[7:0] = ccs_read;
				pwm_art_pkg::IDX_CAPTURE_VALUE_1: rsp_d.rdata[7:0] = cap_val_q[0];
				pwm_art_pkg::IDX_CAPTURE_VALUE_2: rsp_d.rdata[7:0] = cap_val_q[1];
				default: rsp_d.rdata = pwm_art_pkg::READ_UNMAPPED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			// Level is kept with the pin disabled, so enabling it shows no glitch
			// polarity applied after the level, so a change shows at once
			wave_d[c] = level_d[c] ^ output_control_d[pwm_art_pkg::OC_POLARITY_LO + c];
			oe_d[c] = output_control_d[pwm_art_pkg::OC_ENABLE_LO + c];
		end
		// Interrupt lines follow the next flag state so they match the flags
		// capture requests gated by enables
		cap_irq_d = cap_flag_d & cap_ie_d;
		ovf_irq_d = ovf_flag_d & ovf_ie_d;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// everything clears on reset
	// The asynchronous reset branch loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 4; c++) begin
				duty_q[c] <= pwm_art_pkg::REG_RESET;
				shadow_q[c] <= pwm_art_pkg::REG_RESET;
			end
			cap_val_q[0] <= pwm_art_pkg::REG_RESET;
			cap_val_q[1] <= pwm_art_pkg::REG_RESET;
			output_control_q <= pwm_art_pkg::REG_RESET;
			ext_sel_q <= 1'b0;
			prescale_sel_q <= 3'h0;
			run_q <= 1'b0;
			ovf_ie_q <= 1'b0;
			ovf_flag_q <= 1'b0;
			counter_q <= pwm_art_pkg::REG_RESET;
			prescaler_q <= pwm_art_pkg::PRESCALE_RESET;
			reload_q <= pwm_art_pkg::REG_RESET;
			cap_edge_q <= 2'h0;
			cap_ie_q <= 2'h0;
			cap_flag_q <= 2'h0;
			// Pin history resets low; the default falling select cannot fire on it
			cap_prev_q <= 2'h0;
			ext_prev_q <= 1'b0;
			level_q <= 4'h0;
			wave_q <= 4'h0;
			oe_q <= 4'h0;
			ovf_irq_q <= 1'b0;
			cap_irq_q <= 2'h0;
			rsp_q <= '0;
		end else begin
			duty_q <= duty_d;
			shadow_q <= shadow_d;
			cap_val_q <= cap_val_d;
			output_control_q <= output_control_d;
			ext_sel_q <= ext_sel_d;
			prescale_sel_q <= prescale_sel_d;
			run_q <= run_d;
			ovf_ie_q <= ovf_ie_d;
			ovf_flag_q <= ovf_flag_d;
			counter_q <= counter_d;
			prescaler_q <= prescaler_d;
			reload_q <= reload_d;
			cap_edge_q <= cap_edge_d;
			cap_ie_q <= cap_ie_d;
			cap_flag_q <= cap_flag_d;
			cap_prev_q <= cap_prev_d;
			ext_prev_q <= ext_prev_d;
			level_q <= level_d;
			wave_q <= wave_d;
			oe_q <= oe_d;
			ovf_irq_q <= ovf_irq_d;
			cap_irq_q <= cap_irq_d;
			rsp_q <= rsp_d;
		end
	end

	// Ports straight from flip-flops
	// No output depends on a bus input through logic
	assign prdata = rsp_q.rdata;
	assign pready = rsp_q.ready;
	assign pslverr = rsp_q.slverr;
	assign waveform_out = wave_q;
	assign waveform_oe = oe_q;
	assign overflow_irq = ovf_irq_q;
	assign capture_irq = cap_irq_q;

endmodule : pwm_art_timer

/* pwm_art_timer_assertions.sv */
// Checker for the PWM auto-reload timer, port level only.
// Assumes it is bound onto pwm_art_timer; index = paddr[9:2].
`timescale 1ns/1ns
module pwm_art_timer_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_clock_in,
	input wire logic [1:0] capture_pin,
	input wire logic [3:0] waveform_out,
	input wire logic [3:0] waveform_oe,
	input wire logic overflow_irq,
	input wire logic [1:0] capture_irq
);
	// ----------------
	// Helpers
	// ----------------
	logic rd;
	logic wr;
	logic [7:0] idx;
	logic clr_c;
	logic clr_o;
	logic clr_d;
	// Completed reads, writes and flag clearing accesses
	assign idx = paddr[9:2];
	assign rd = psel && penable && pready && !pwrite;
	assign wr = psel && penable && pready && pwrite;
	assign clr_c = (rd && idx == 8'h7C) || (wr && idx == 8'h7B);
	assign clr_d = (rd && idx == 8'h7D) || (wr && idx == 8'h7B);
	assign clr_o = (rd || wr) && idx == 8'h78;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------
	// Properties
	// ----------------
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no answer after one wait state");
	property p_phase; pready |-> psel && penable; endproperty
	a_phase: assert property (p_phase) else $error("ready outside access phase");
	property p_unmap; rd && (idx < 8'h73 || idx > 8'h7D) |-> prdata == 32'h00000000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_resv; rd && idx == 8'h7B |-> prdata[7:6] == 2'b00; endproperty
	a_resv: assert property (p_resv) else $error("reserved capture bits set");
	property p_force; rd && idx == 8'h78 |-> !prdata[2]; endproperty
	a_force: assert property (p_force) else $error("force reload bit reads one");
	property p_oe_set; wr && idx == 8'h77 |=> waveform_oe == $past(pwdata[7:4]); endproperty
	a_oe_set: assert property (p_oe_set) else $error("enable pins differ from write");
	property p_oe_hold; !(wr && idx == 8'h77) |=> $stable(waveform_oe); endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("enable pins moved unasked");
	property p_cap_fall; $fell(capture_irq[0]) |-> $past(clr_c) || $past(clr_c, 2); endproperty
	a_cap_fall: assert property (p_cap_fall) else $error("capture request dropped unread");
	property p_ovf_fall; $fell(overflow_irq) |-> $past(clr_o) || $past(clr_o, 2); endproperty
	a_ovf_fall: assert property (p_ovf_fall) else $error("overflow request dropped unread");
	property p_cap2_fall; $fell(capture_irq[1]) |-> $past(clr_d) || $past(clr_d, 2); endproperty
	a_cap2_fall: assert property (p_cap2_fall) else $error("second capture request dropped unread");
	property p_noerr; pready |-> !pslverr; endproperty
	a_noerr: assert property (p_noerr) else $error("error response given");
endmodule : pwm_art_timer_assertions

bind pwm_art_timer pwm_art_timer_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .ext_clock_in, .capture_pin, .waveform_out, .waveform_oe,
	.overflow_irq, .capture_irq);

/* tb_top.sv */
// Self-checking bench for the PWM auto-reload timer.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ns
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_clock_in = 1'b0;
	logic [1:0] capture_pin = 2'b10;
	logic [3:0] waveform_out;
	logic [3:0] waveform_oe;
	logic overflow_irq;
	logic [1:0] capture_irq;
	int mismatches = 0;
	int checks = 0;
	logic [31:0] q;
	logic lv;
	int n;
	// Clock and device
	always #50 pclk = ~pclk;
	pwm_art_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_clock_in, .capture_pin, .waveform_out, .waveform_oe, .overflow_irq, .capture_irq);
	// ----------------
	// Shared tasks
	// ----------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One APB transfer; only the watchdog ends the wait for pready
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'b1, i, d);
	endtask : wr
	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		chk(q, {24'h000000, e});
	endtask : rc
	// High samples of channel 0 over eight cycles
	task automatic hi(output int c);
		c = 0;
		repeat (8) begin
			@(negedge pclk);
			c += (waveform_out[0] === 1'b1);
		end
	endtask : hi
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs;
		for (int i = 0; i < 11; i++) rc(8'h73 + 8'(i), 8'h00);
		wr(8'h72, 8'hA5);
		rc(8'h72, 8'h00);
		wr(8'h73, 8'h3C);
		wr(8'h77, 8'hA5);
		wr(8'h7A, 8'h5A);
		wr(8'h7C, 8'h77);
		wr(8'h7B, 8'hFF);
		rc(8'h73, 8'h3C);
		rc(8'h77, 8'hA5);
		rc(8'h7A, 8'h5A);
		rc(8'h7C, 8'h00);
		rc(8'h7B, 8'h3C);
		chk({28'h0000000, waveform_oe}, 32'h0000000A);
		chk({28'h0000000, waveform_out}, 32'h00000005);
		$display("register test done");
	endtask : t_regs
	task automatic t_count;
		wr(8'h78, 8'h78);
		wr(8'h79, 8'h10);
		rc(8'h79, 8'h10);
		repeat (140) @(posedge pclk);
		rc(8'h79, 8'h11);
		wr(8'h7A, 8'h80);
		wr(8'h78, 8'h7C);
		rc(8'h78, 8'h78);
		rc(8'h79, 8'h80);
		$display("count test done");
	endtask : t_count
	task automatic t_pwm;
		wr(8'h7A, 8'hFC);
		wr(8'h77, 8'h10);
		for (int d = 0; d < 4; d++) begin
			wr(8'h76, 8'hFC + 8'(d));
			wr(8'h78, 8'h0E);
			repeat (8) @(posedge pclk);
			hi(n);
			chk(32'(n), 32'(2 * d + 2));
		end
		wr(8'h78, 8'h02);
		// request shows after the write edge
		@(negedge pclk);
		chk({31'h0, overflow_irq}, 32'h00000001);
		rc(8'h78, 8'h03);
		rc(8'h78, 8'h02);
		chk({31'h0, overflow_irq}, 32'h00000000);
		@(negedge pclk);
		lv = waveform_out[0];
		wr(8'h77, 8'h11);
		@(negedge pclk);
		chk({31'h0, waveform_out[0]}, {31'h0, ~lv});
		$display("pwm test done");
	endtask : t_pwm
	task automatic t_cap;
		wr(8'h79, 8'h42);
		wr(8'h7B, 8'h1C);
		capture_pin <= 2'b01;
		repeat (4) @(posedge pclk);
		chk({30'h0, capture_irq}, 32'h00000003);
		rc(8'h7B, 8'h1F);
		wr(8'h79, 8'h50);
		capture_pin <= 2'b10;
		repeat (4) @(posedge pclk);
		capture_pin <= 2'b01;
		rc(8'h7C, 8'h42);
		rc(8'h7B, 8'h1E);
		rc(8'h7D, 8'h42);
		rc(8'h7B, 8'h1C);
		wr(8'h7B, 8'h10);
		capture_pin <= 2'b10;
		repeat (4) @(posedge pclk);
		rc(8'h7B, 8'h10);
		capture_pin <= 2'b01;
		repeat (4) @(posedge pclk);
		chk({30'h0, capture_irq}, 32'h00000000);
		rc(8'h7B, 8'h13);
		rc(8'h7C, 8'h50);
		$display("capture test done");
	endtask : t_cap
	task automatic t_ext;
		wr(8'h79, 8'h20);
		wr(8'h78, 8'h88);
		repeat (3) begin
			@(posedge pclk);
			ext_clock_in <= 1'b1;
			repeat (2) @(posedge pclk);
			ext_clock_in <= 1'b0;
		end
		repeat (3) @(posedge pclk);
		rc(8'h79, 8'h23);
		$display("external clock test done");
	endtask : t_ext
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_count;
		t_pwm;
		t_cap;
		t_ext;
		end_sim;
	end
	// Watchdog
	initial begin
		#(100 * 20000);
		mismatches++;
		end_sim;
	end
endmodule : tb_top
